// [hw/gex_cfg.svh]
`ifndef GEX_CFG_SVH
`define GEX_CFG_SVH

// Clock and filter timing
`define GEX_CLK_NS         40
`define GEX_SPIKE_NS       50
`define GEX_SPIKE_CYC      ((`GEX_SPIKE_NS + `GEX_CLK_NS - 1) / `GEX_CLK_NS)

// Serial register indices (command byte low bits)
`define GEX_IDX_IN0        3'h0
`define GEX_IDX_IN1        3'h1
`define GEX_IDX_OUT0       3'h2
`define GEX_IDX_OUT1       3'h3
`define GEX_IDX_POL0       3'h4
`define GEX_IDX_POL1       3'h5
`define GEX_IDX_CFG0       3'h6
`define GEX_IDX_CFG1       3'h7

// Serial register reset values
`define GEX_RST_OUT        8'hFF
`define GEX_RST_POL        8'h00
`define GEX_RST_CFG        8'hFF

// Fixed upper part of the target address
`define GEX_ADDR_UPPER     4'h4

// Wishbone word indices (address bits 7:2)
`define GEX_WB_STATUS      6'h00
`define GEX_WB_MASK        6'h01
`define GEX_WB_STATE       6'h02
`define GEX_WB_CTRL        6'h03

// Status and mask bit positions and width
`define GEX_EV_ALERT       0
`define GEX_EV_WRITE       1
`define GEX_EV_SNAP        2
`define GEX_EV_W           3

// Control bits and reset values
`define GEX_CTRL_EN        0
`define GEX_RST_CTRL       1'h1
`define GEX_RST_MASK       3'h0

`endif

// [hw/gex_pkg.sv]
package gex_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_CMD,
    ST_ACK_CMD,
    ST_WDAT,
    ST_ACK_WDAT,
    ST_RDAT,
    ST_ACK_RDAT
  } gex_state_t;

  typedef logic [2:0] gex_idx_t;

endpackage

// [hw/gex_filt.sv]
`timescale 1ns/100ps
module gex_filt #(
  parameter int WIDTH  = 2,
  parameter int STABLE = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Raw pins and filtered levels
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] flt_o
);

  localparam int CW = $clog2(STABLE + 1);

  logic [WIDTH-1:0]         meta;
  logic [WIDTH-1:0]         sync;
  logic [WIDTH-1:0][CW-1:0] cnt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '1;
      sync <= '1;
    end else begin
      meta <= raw_i;
      sync <= meta;
    end
  end

  // Level passes only after holding STABLE cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_o <= '1;
      cnt   <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync[i] == flt_o[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] >= CW'(STABLE - 1)) begin
          flt_o[i] <= sync[i];
          cnt[i]   <= '0;
        end else begin
          cnt[i] <= cnt[i] + CW'(1);
        end
      end
    end
  end

endmodule

// [hw/gex_top.sv]
`timescale 1ns/100ps
`include "gex_cfg.svh"
// How it works
// - After reset all sixteen lines are inputs with their drivers off.
// - Each line has its own direction bit in one of two 8-bit direction registers written by the master.
// - The input register holds sampled line levels and outputs are driven from the output register bits.
// - A set polarity bit inverts that line's value as read from the input register.
// - Every register returns its current contents when read over the serial link.
// - The alert is asserted while any input line differs from its held input register value.
// - The alert pin is only pulled low, and released otherwise.
// - Reset returns all registers to defaults and the serial engine to idle.
// - The target address is a fixed upper part plus three strap bits.
// - The serial target works at bus clocks up to fast mode, which the master must not exceed.
// - Short noise pulses on the serial clock and data inputs are filtered out.
// - Lines stay undriven inputs with no glitches while reset completes.
module gex_top #(
  parameter logic [3:0] ADDR_UPPER = `GEX_ADDR_UPPER
) (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  // Serial link
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // Address straps
  input  wire logic        ADDR_STRAP_BIT0_I,
  input  wire logic        ADDR_STRAP_BIT1_I,
  input  wire logic        ADDR_STRAP_BIT2_I,
  // Port lines
  input  wire logic [7:0]  PORT0_LINES_I,
  output logic      [7:0]  PORT0_LINES_O,
  output logic      [7:0]  PORT0_LINES_OE_O,
  input  wire logic [7:0]  PORT1_LINES_I,
  output logic      [7:0]  PORT1_LINES_O,
  output logic      [7:0]  PORT1_LINES_OE_O,
  // Change alert, open drain
  output logic             CHANGE_ALERT_N_O,
  output logic             CHANGE_ALERT_N_OE_O,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Interrupt
  output logic             IRQ_O
);

  logic [1:0]  flt;
  logic        scl_f;
  logic        sda_f;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [15:0] line_meta;
  logic [15:0] line_sync;
  logic [2:0]  strap_meta;
  logic [2:0]  strap_sync;
  logic [2:0]  strap;
  logic        strap_done;
  logic [7:0]  out0;
  logic [7:0]  out1;
  logic [7:0]  pol0;
  logic [7:0]  pol1;
  logic [7:0]  cfg0;
  logic [7:0]  cfg1;
  logic [15:0] held;
  logic        held_init;
  gex_pkg::gex_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic        more;
  gex_pkg::gex_idx_t cmd;
  logic        wr_pulse;
  gex_pkg::gex_idx_t wr_idx;
  logic [7:0]  wr_data;
  logic        snap_pulse;
  logic        snap_port;
  logic [15:0] diff;
  logic        alert;
  logic [`GEX_EV_W-1:0] status;
  logic [`GEX_EV_W-1:0] mask;
  logic [`GEX_EV_W-1:0] events;
  logic        ctrl_en;
  logic        wb_req;
  logic [5:0]  wb_idx;
  logic        addr_match;
  logic [7:0]  rd_cur;
  logic [7:0]  rd_nxt;
  logic [1:0]  fill;

  // Register read decode, used for every byte loaded for the master
  function automatic logic [7:0] reg_read(input gex_pkg::gex_idx_t idx, input logic [15:0] lines,
                                          input logic [7:0] o0, input logic [7:0] o1,
                                          input logic [7:0] p0, input logic [7:0] p1,
                                          input logic [7:0] c0, input logic [7:0] c1);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      `GEX_IDX_IN0:  r = lines[7:0] ^ p0;
      `GEX_IDX_IN1:  r = lines[15:8] ^ p1;
      `GEX_IDX_OUT0: r = o0;
      `GEX_IDX_OUT1: r = o1;
      `GEX_IDX_POL0: r = p0;
      `GEX_IDX_POL1: r = p1;
      `GEX_IDX_CFG0: r = c0;
      `GEX_IDX_CFG1: r = c1;
    endcase
    return r;
  endfunction

  // Byte for the current index and for its pair partner
  assign rd_cur = reg_read(cmd, line_sync, out0, out1, pol0, pol1, cfg0, cfg1);
  assign rd_nxt = reg_read(cmd ^ 3'h1, line_sync, out0, out1, pol0, pol1, cfg0, cfg1);

  // Spike filter on the serial pins
  gex_filt #(
    .WIDTH  (2),
    .STABLE (`GEX_SPIKE_CYC)
  ) u_filt (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .raw_i   ({SDA_I, SCL_I}),
    .flt_o   (flt)
  );

  assign scl_f = flt[0];
  assign sda_f = flt[1];

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign scl_rise  = scl_f & ~scl_d;
  assign scl_fall  = ~scl_f & scl_d;
  assign start_det = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_det  = scl_f & scl_d & ~sda_d & sda_f;

  // Port line and strap synchronisers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      line_meta  <= 16'h0000;
      line_sync  <= 16'h0000;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      line_meta  <= {PORT1_LINES_I, PORT0_LINES_I};
      line_sync  <= line_meta;
      strap_meta <= {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I};
      strap_sync <= strap_meta;
    end
  end

  // Straps caught once after reset release, once the synchroniser has filled
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      strap      <= 3'h0;
      strap_done <= 1'b0;
    end else if (!strap_done && held_init) begin
      strap      <= strap_sync;
      strap_done <= 1'b1;
    end
  end

  assign addr_match = ctrl_en && strap_done && (shreg[7:1] == {ADDR_UPPER, strap});

  // Serial target engine
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state      <= gex_pkg::ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      more       <= 1'b0;
      cmd        <= `GEX_IDX_IN0;
      SDA_OE_O   <= 1'b0;
      wr_pulse   <= 1'b0;
      wr_idx     <= `GEX_IDX_IN0;
      wr_data    <= 8'h00;
      snap_pulse <= 1'b0;
      snap_port  <= 1'b0;
    end else begin
      wr_pulse   <= 1'b0;
      snap_pulse <= 1'b0;
      if (start_det) begin
        state    <= gex_pkg::ST_ADDR;
        bit_cnt  <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else if (stop_det) begin
        state    <= gex_pkg::ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else begin
        unique case (state)
          gex_pkg::ST_IDLE: begin
            SDA_OE_O <= 1'b0;
          end
          gex_pkg::ST_ADDR, gex_pkg::ST_CMD, gex_pkg::ST_WDAT: begin
            if (scl_rise && bit_cnt < 4'h8) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == gex_pkg::ST_ADDR) begin
                if (addr_match) begin
                  SDA_OE_O <= 1'b1;
                  more     <= shreg[0];
                  state    <= gex_pkg::ST_ACK_ADDR;
                end else begin
                  state <= gex_pkg::ST_IDLE;
                end
              end else if (state == gex_pkg::ST_CMD) begin
                cmd      <= shreg[2:0];
                SDA_OE_O <= 1'b1;
                state    <= gex_pkg::ST_ACK_CMD;
              end else begin
                wr_pulse <= 1'b1;
                wr_idx   <= cmd;
                wr_data  <= shreg;
                cmd      <= cmd ^ 3'h1;
                SDA_OE_O <= 1'b1;
                state    <= gex_pkg::ST_ACK_WDAT;
              end
            end
          end
          gex_pkg::ST_ACK_ADDR: begin
            if (scl_fall) begin
              if (more) begin
                shreg      <= rd_cur;
                SDA_OE_O   <= ~rd_cur[7];
                snap_pulse <= (cmd[2:1] == 2'b00);
                snap_port  <= cmd[0];
                state      <= gex_pkg::ST_RDAT;
              end else begin
                SDA_OE_O <= 1'b0;
                state    <= gex_pkg::ST_CMD;
              end
            end
          end
          gex_pkg::ST_ACK_CMD, gex_pkg::ST_ACK_WDAT: begin
            if (scl_fall) begin
              SDA_OE_O <= 1'b0;
              state    <= gex_pkg::ST_WDAT;
            end
          end
          gex_pkg::ST_RDAT: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                bit_cnt  <= 4'h0;
                SDA_OE_O <= 1'b0;
                state    <= gex_pkg::ST_ACK_RDAT;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                SDA_OE_O <= ~shreg[6];
              end
            end
          end
          gex_pkg::ST_ACK_RDAT: begin
            if (scl_rise) begin
              more <= ~sda_f;
            end else if (scl_fall) begin
              if (more) begin
                cmd        <= cmd ^ 3'h1;
                shreg      <= rd_nxt;
                SDA_OE_O   <= ~rd_nxt[7];
                snap_pulse <= (cmd[2:1] == 2'b00);
                snap_port  <= ~cmd[0];
                state      <= gex_pkg::ST_RDAT;
              end else begin
                state <= gex_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign SDA_O = 1'b0;

  // Output, polarity and direction registers
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      out0 <= `GEX_RST_OUT;
      out1 <= `GEX_RST_OUT;
      pol0 <= `GEX_RST_POL;
      pol1 <= `GEX_RST_POL;
      cfg0 <= `GEX_RST_CFG;
      cfg1 <= `GEX_RST_CFG;
    end else if (wr_pulse) begin
      unique case (wr_idx)
        `GEX_IDX_OUT0: out0 <= wr_data;
        `GEX_IDX_OUT1: out1 <= wr_data;
        `GEX_IDX_POL0: pol0 <= wr_data;
        `GEX_IDX_POL1: pol1 <= wr_data;
        `GEX_IDX_CFG0: cfg0 <= wr_data;
        `GEX_IDX_CFG1: cfg1 <= wr_data;
        default: ;
      endcase
    end
  end

  // Held input values: loaded once the synchronisers have filled, refreshed on input register reads
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fill      <= 2'h0;
      held      <= 16'h0000;
      held_init <= 1'b0;
    end else if (!held_init) begin
      fill <= fill + 2'h1;
      if (fill == 2'h2) begin
        held      <= line_sync;
        held_init <= 1'b1;
      end
    end else if (snap_pulse) begin
      if (snap_port) begin
        held[15:8] <= line_sync[15:8];
      end else begin
        held[7:0] <= line_sync[7:0];
      end
    end
  end

  // Line drivers, disabled for input-configured lines
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PORT0_LINES_O    <= `GEX_RST_OUT;
      PORT1_LINES_O    <= `GEX_RST_OUT;
      PORT0_LINES_OE_O <= 8'h00;
      PORT1_LINES_OE_O <= 8'h00;
    end else begin
      PORT0_LINES_O    <= out0;
      PORT1_LINES_O    <= out1;
      PORT0_LINES_OE_O <= ~cfg0;
      PORT1_LINES_OE_O <= ~cfg1;
    end
  end

  // Change alert
  assign diff = (line_sync ^ held) & {cfg1, cfg0};

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alert <= 1'b0;
    end else begin
      alert <= held_init && (|diff);
    end
  end

  assign CHANGE_ALERT_N_O    = 1'b0;
  assign CHANGE_ALERT_N_OE_O = alert;

  // Wishbone slave
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_idx = WB_ADR_I[7:2];
  assign events = {snap_pulse, wr_pulse, (|diff) & held_init & ~alert};

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        unique case (wb_idx)
          `GEX_WB_STATUS: WB_DAT_O <= {29'h0, status};
          `GEX_WB_MASK:   WB_DAT_O <= {29'h0, mask};
          `GEX_WB_STATE:  WB_DAT_O <= {12'h000, alert, strap, line_sync};
          `GEX_WB_CTRL:   WB_DAT_O <= {31'h0, ctrl_en};
          default:        WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mask    <= `GEX_RST_MASK;
      ctrl_en <= `GEX_RST_CTRL;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
      if (wb_idx == `GEX_WB_MASK) begin
        mask <= WB_DAT_I[`GEX_EV_W-1:0];
      end
      if (wb_idx == `GEX_WB_CTRL) begin
        ctrl_en <= WB_DAT_I[`GEX_CTRL_EN];
      end
    end
  end

  // Sticky status, cleared by read; a new event wins over the clear
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status <= '0;
    end else if (wb_req && !WB_WE_I && wb_idx == `GEX_WB_STATUS) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status & mask);
    end
  end

endmodule

// [dv/gex_sva.sv]
`timescale 1ns/100ps
module gex_sva (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  // Serial link and port lines
  input  wire logic        SCL_I,
  input  wire logic        SDA_OE_O,
  input  wire logic [7:0]  PORT0_LINES_I,
  input  wire logic [7:0]  PORT1_LINES_I,
  input  wire logic [7:0]  PORT0_LINES_O,
  input  wire logic [7:0]  PORT0_LINES_OE_O,
  input  wire logic [7:0]  PORT1_LINES_OE_O,
  // Alert and register bus
  input  wire logic        CHANGE_ALERT_N_O,
  input  wire logic        CHANGE_ALERT_N_OE_O,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_ACK_O,
  input  wire logic [31:0] WB_DAT_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  logic        scl_d;
  logic [15:0] line_d;
  logic [7:0]  scl_quiet;
  logic [7:0]  line_quiet;
  // Cycles since the link clock or a port line last moved
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_d      <= 1'b1;
      line_d     <= 16'h0000;
      scl_quiet  <= 8'hFF;
      line_quiet <= 8'hFF;
    end else begin
      scl_d      <= SCL_I;
      line_d     <= {PORT1_LINES_I, PORT0_LINES_I};
      scl_quiet  <= (scl_d != SCL_I) ? 8'h00 : scl_quiet + {7'h00, scl_quiet != 8'hFF};
      line_quiet <= (line_d != {PORT1_LINES_I, PORT0_LINES_I}) ? 8'h00 : line_quiet + {7'h00, line_quiet != 8'hFF};
    end
  end
  sequence wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_wb_ack_once: assert property (wb_req |=> ack_pulse)
    else $error("ack is not one pulse one cycle after request");
  a_ack_has_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_lines_reset_in: assert property (!$past(RESETN_I) |-> {PORT1_LINES_OE_O, PORT0_LINES_OE_O} == 16'h0000 && PORT0_LINES_O == 8'hFF)
    else $error("lines not undriven inputs after reset");
  a_dir_needs_link: assert property ($changed({PORT1_LINES_OE_O, PORT0_LINES_OE_O}) |-> scl_quiet < 8'd40)
    else $error("direction changed without link traffic");
  a_alert_od_low: assert property (CHANGE_ALERT_N_O == 1'b0)
    else $error("alert pin drives high");
  a_alert_cause: assert property ($rose(CHANGE_ALERT_N_OE_O) |-> line_quiet < 8'd8 || scl_quiet < 8'd40)
    else $error("alert rose with no cause");
  a_alert_clear: assert property ($fell(CHANGE_ALERT_N_OE_O) |-> line_quiet < 8'd8 || scl_quiet < 8'd40)
    else $error("alert fell with no cause");
  a_sda_low_phase: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data moved while link clock high");
  a_sda_idle_free: assert property (scl_quiet > 8'd100 |-> !SDA_OE_O)
    else $error("data held low on idle link");
endmodule

// [dv/gex_i2c_mst.sv]
`timescale 1ns/100ps
module gex_i2c_mst (
  // Clock and sensed data wire
  input  wire logic clk_i,
  input  wire logic sda_i,
  // Pulls, high pulls the wire low
  output logic      scl_oe_o = 1'b0,
  output logic      sda_oe_o = 1'b0
);
  // Phases in clocks, 6 + 2 gives the 320 ns period
  int lo = 6;
  int hi = 2;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data falls while clock high, also repeated start
  task automatic start();
    sda_oe_o <= 1'b0;
    tick(lo / 2);
    scl_oe_o <= 1'b0;
    tick(8);
    sda_oe_o <= 1'b1;
    tick(8);
    scl_oe_o <= 1'b1;
    tick(lo / 2);
  endtask
  // Data set mid low phase, sampled at end of high phase
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o <= ~b;
    tick(lo - lo / 2);
    scl_oe_o <= 1'b0;
    tick(hi);
    r = sda_i;
    scl_oe_o <= 1'b1;
    tick(lo / 2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(nak, a);
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(lo - lo / 2);
    scl_oe_o <= 1'b0;
    tick(8);
    sda_oe_o <= 1'b0;
    tick(16);
  endtask
endmodule

// [dv/test_i2c_gpio_expander_16bit.sv]
`timescale 1ns/100ps
`include "gex_cfg.svh"
module test_i2c_gpio_expander_16bit;
  logic        CLK_SYS_I = 1'b0;
  logic        RESETN_I = 1'b0;
  logic        ADDR_STRAP_BIT0_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT2_I, WB_CYC_I, WB_STB_I, WB_WE_I;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic        SDA_O, SDA_OE_O, WB_ACK_O, IRQ_O, CHANGE_ALERT_N_O, CHANGE_ALERT_N_OE_O, scl_oe, sda_oe;
  logic [7:0]  PORT0_LINES_O, PORT0_LINES_OE_O, PORT1_LINES_O, PORT1_LINES_OE_O, ext0, ext1;
  logic [7:0]  mr [8];
  logic [2:0]  strap;
  logic [6:0]  dev;
  int          fails = 0, checks_done = 0, cyc = 0, seed = 32'h499c;
  wire logic       SCL_I = ~scl_oe;
  wire logic       SDA_I = ~sda_oe & (SDA_OE_O ? SDA_O : 1'b1);
  wire logic [7:0] PORT0_LINES_I = (PORT0_LINES_OE_O & PORT0_LINES_O) | (~PORT0_LINES_OE_O & ext0);
  wire logic [7:0] PORT1_LINES_I = (PORT1_LINES_OE_O & PORT1_LINES_O) | (~PORT1_LINES_OE_O & ext1);
  wire logic       alert_n = CHANGE_ALERT_N_OE_O ? CHANGE_ALERT_N_O : 1'b1;
  gex_top uut (.*);
  gex_i2c_mst mst (.clk_i(CLK_SYS_I), .sda_i(SDA_I), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));
  always #20 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= {a, 2'b00};
    WB_DAT_I <= d;
    @(posedge CLK_SYS_I);
    while (WB_ACK_O !== 1'b1) begin
      @(posedge CLK_SYS_I);
    end
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask
  task automatic reset_dut();
    RESETN_I <= 1'b0;
    repeat (16) @(posedge CLK_SYS_I);
    RESETN_I <= 1'b1;
    repeat (8) @(posedge CLK_SYS_I);
    mr = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
    chk({PORT1_LINES_OE_O, PORT0_LINES_OE_O}, 0);
    chk({PORT1_LINES_O, PORT0_LINES_O}, 16'hFFFF);
  endtask
  task automatic i2c_wr(input logic [6:0] ad, input logic [2:0] ix, input logic [7:0] d0, input logic [7:0] d1,
                        input logic ok);
    logic [7:0] q;
    logic       a;
    mst.start();
    mst.xfer({ad, 1'b0}, 1'b1, q, a);
    chk(a, {31'h0, ~ok});
    if (ok) begin
      mst.xfer({5'h00, ix}, 1'b1, q, a);
      mst.xfer(d0, 1'b1, q, a);
      mst.xfer(d1, 1'b1, q, a);
      chk(a, 0);
      mr[ix] = d0;
      mr[ix ^ 3'h1] = d1;
    end
    mst.stop();
  endtask
  // Live level through the line, inverted by its polarity bit
  function automatic logic [7:0] exp_reg(input logic [2:0] ix);
    logic [7:0] lv;
    lv = ix[0] ? ((mr[7] & ext1) | (~mr[7] & mr[3])) : ((mr[6] & ext0) | (~mr[6] & mr[2]));
    return (ix[2:1] == 2'b00) ? (lv ^ mr[{2'b10, ix[0]}]) : mr[ix];
  endfunction
  task automatic rdchk(input logic [2:0] ix);
    logic [7:0] q;
    logic [7:0] q1;
    logic       a;
    mst.start();
    mst.xfer({dev, 1'b0}, 1'b1, q, a);
    mst.xfer({5'h00, ix}, 1'b1, q, a);
    mst.start();
    mst.xfer({dev, 1'b1}, 1'b1, q, a);
    chk(a, 0);
    mst.xfer(8'hFF, 1'b0, q, a);
    mst.xfer(8'hFF, 1'b1, q1, a);
    mst.stop();
    chk(q, exp_reg(ix));
    chk(q1, exp_reg(ix ^ 3'h1));
  endtask
  task automatic wait_al(input logic v);
    for (int n = 0; n < 20 && CHANGE_ALERT_N_OE_O !== v; n++) @(posedge CLK_SYS_I);
    repeat (2) @(posedge CLK_SYS_I);
    chk(CHANGE_ALERT_N_OE_O, v);
  endtask
  initial begin
    logic [31:0] q;
    {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'b000;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'h1;
    WB_DAT_I = 32'h0000_0000;
    ext0 = 8'($random(seed));
    ext1 = 8'($random(seed));
    strap = 3'($random(seed));
    {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I} = strap;
    dev = {`GEX_ADDR_UPPER, strap};
    reset_dut();
    wb(0, `GEX_WB_CTRL, 0, q);
    chk(q, 1);
    wb(0, `GEX_WB_MASK, 0, q);
    chk(q, 0);
    wb(0, `GEX_WB_STATE, 0, q);
    chk(q[19:0], {1'b0, strap, ext1, ext0});
    wb(0, 6'h20, 0, q);
    chk(q, 0);
    i2c_wr(dev ^ 7'h01, 3'h2, 8'h00, 8'h00, 1'b0);
    wb(1, `GEX_WB_CTRL, 0, q);
    i2c_wr(dev, 3'h2, 8'h00, 8'h00, 1'b0);
    wb(1, `GEX_WB_CTRL, 1, q);
    for (int r = 0; r < 4; r++) begin
      mst.lo = (r == 3) ? 10 : 6;
      mst.hi = (r == 3) ? 10 : 2;
      ext0 <= 8'($random(seed));
      ext1 <= 8'($random(seed));
      for (int i = 2; i < 8; i += 2) i2c_wr(dev, i[2:0], 8'($random(seed)), 8'($random(seed)), 1'b1);
      chk({PORT1_LINES_O, PORT0_LINES_O}, {mr[3], mr[2]});
      chk({PORT1_LINES_OE_O, PORT0_LINES_OE_O}, {16'h0000, ~mr[7], ~mr[6]});
      for (int i = 0; i < 8; i += 2) rdchk(i[2:0]);
    end
    wb(1, `GEX_WB_MASK, 1, q);
    i2c_wr(dev, 3'h6, 8'hFF, 8'hFF, 1'b1);
    rdchk(3'h0);
    wb(0, `GEX_WB_STATUS, 0, q);
    wait_al(0);
    for (int k = 0; k < 3; k++) begin
      ext0[k] <= ~ext0[k];
      wait_al(1);
      chk({alert_n, IRQ_O}, 2'b01);
      if (k == 1) rdchk(3'h0);
      else ext0[k] <= ~ext0[k];
      wait_al(0);
    end
    wb(0, `GEX_WB_STATUS, 0, q);
    chk(q, 32'h0000_0005);
    wb(0, `GEX_WB_STATUS, 0, q);
    chk({q[30:0], IRQ_O}, 0);
    wb(1, `GEX_WB_MASK, 0, q);
    ext0[7] <= ~ext0[7];
    wait_al(1);
    chk(IRQ_O, 0);
    reset_dut();
    rdchk(3'h6);
    end_of_test();
  end
endmodule
bind gex_top gex_sva u_sva (.*);
